// ---- eeprom_port_pkg.sv ----
package eeprom_port_pkg;

    localparam int CLK_FREQ_MHZ          = 100;
    localparam int PAGE_LOAD_TIMEOUT_US  = 100;
    localparam int PROG_TIME_MAX_US      = 5000;
    // least time: rounds up, never below one cycle
    localparam int PAGE_LOAD_CYCLES      = (PAGE_LOAD_TIMEOUT_US * CLK_FREQ_MHZ < 1) ? 1 :
                                           PAGE_LOAD_TIMEOUT_US * CLK_FREQ_MHZ;
    // longest time: rounds down, never below one cycle
    localparam int PROG_MAX_CYCLES       = (PROG_TIME_MAX_US * CLK_FREQ_MHZ < 1) ? 1 :
                                           PROG_TIME_MAX_US * CLK_FREQ_MHZ;

    localparam int ADDR_W                = 16;
    localparam int DATA_W                = 8;
    localparam int ARRAY_AW              = 13;
    localparam int PLANE_BIT             = 12;
    localparam int SECTION_LSB           = 10;
    localparam int SECTION_COUNT         = 8;
    localparam int PAGE_LSB              = 5;
    localparam int PAGE_BYTES            = 32;
    localparam int TOGGLE_BIT            = 6;

    localparam logic [ADDR_W-1:0]  ADDR_RESET   = 16'h0000;
    localparam logic [DATA_W-1:0]  DATA_RESET   = 8'h00;
    localparam logic [DATA_W-1:0]  STATUS_BASE  = 8'h00;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_PROG = 2'b10
    } wr_state_t;

endpackage

// ---- pin_sync.sv ----
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb begin
        meta_next = pin_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign pin_out = sync_reg;
endmodule

// ---- muxed_bus_eeprom_write_port.sv ----
// Function
// - latch 16-bit address on strobe fall
// - capture write data on phase-clock fall
// - drive read byte while clock and direction high
// - direction low in high phase starts write
// - two 4K planes chosen by plane bit
// - reads of idle plane continue during programming
// - eight 1K sections, disabled ones stay unchanged
// - section enables kept across power loss
// - page writes of one to thirty-two bytes
// - each write rising edge restarts load timer
// - write gate decides if page load completes
// - raised write gate before timeout cancels programming
// - select must be valid at strobe fall
// - select and strobe low mean standby
// - programming ends within 5 ms, pollable
// - busy-plane reads invert toggle status bit
// - low address shares lines, upper dedicated
// - data in high phase, address in low
`timescale 1ns/10ps
module muxed_bus_eeprom_write_port
    import eeprom_port_pkg::*;
#(
    parameter int LOAD_CYCLES = eeprom_port_pkg::PAGE_LOAD_CYCLES,
    parameter int PROG_CYCLES = eeprom_port_pkg::PROG_MAX_CYCLES
) (
    input  wire logic                                CLK,
    input  wire logic                                RSTN,
    input  wire logic [eeprom_port_pkg::DATA_W-1:0]  UPPER_ADDR_INPUTS,
    input  wire logic [eeprom_port_pkg::DATA_W-1:0]  MUXED_ADDR_DATA_IN,
    output logic      [eeprom_port_pkg::DATA_W-1:0]  MUXED_ADDR_DATA_OUT,
    output logic                                     MUXED_ADDR_DATA_OE_N,
    input  wire logic                                ADDR_LATCH_STROBE,
    input  wire logic                                BUS_PHASE_CLOCK,
    input  wire logic                                READ_NOT_WRITE,
    input  wire logic                                CHIP_SELECT,
    input  wire logic                                WRITE_GATE_INPUT,
    input  wire logic                                SECTION_ENABLE_LOAD,
    input  wire logic [eeprom_port_pkg::SECTION_COUNT-1:0] SECTION_ENABLE_DATA,
    output logic                                     STANDBY,
    output logic                                     PROG_BUSY
);
    import eeprom_port_pkg::*;

    localparam int LCW = $clog2(LOAD_CYCLES + 1);
    localparam int PCW = $clog2(PROG_CYCLES + 1);
    localparam int PIW = $clog2(PAGE_BYTES);

    if (LOAD_CYCLES < 1 || PROG_CYCLES < PAGE_BYTES + 1) begin
        $error("cycle counts too small for the write sequencer");
    end

    function automatic logic plane_of(input logic [ADDR_W-1:0] a);
        plane_of = a[PLANE_BIT];
    endfunction

    // reset release through two flops
    logic [1:0] rst_pipe_reg;
    logic [1:0] rst_pipe_next;
    logic       rst_n;
    always_comb rst_pipe_next = {rst_pipe_reg[0], 1'b1};
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_pipe_reg <= 2'b00;
        end else begin
            rst_pipe_reg <= rst_pipe_next;
        end
    end
    assign rst_n = rst_pipe_reg[1];

    // every bus pin passes two flops
    logic [20:0] pins_s;
    pin_sync #(.WIDTH(21)) u_sync (
        .clk     (CLK),
        .rst_n   (rst_n),
        .pin_in  ({UPPER_ADDR_INPUTS, MUXED_ADDR_DATA_IN, ADDR_LATCH_STROBE,
                   BUS_PHASE_CLOCK, READ_NOT_WRITE, CHIP_SELECT, WRITE_GATE_INPUT}),
        .pin_out (pins_s)
    );
    logic [DATA_W-1:0] upper_s;
    logic [DATA_W-1:0] ad_s;
    logic              strobe_s;
    logic              phase_s;
    logic              rnw_s;
    logic              sel_s;
    logic              gate_s;
    assign {upper_s, ad_s, strobe_s, phase_s, rnw_s, sel_s, gate_s} = pins_s;

    // bus front end state
    logic              strobe_d_reg, strobe_d_next;
    logic              phase_d_reg, phase_d_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic              sel_reg, sel_next;
    logic              toggle_reg, toggle_next;
    logic [DATA_W-1:0] dout_reg, dout_next;
    logic              oe_n_reg, oe_n_next;
    logic              standby_reg, standby_next;

    // write sequencer state
    wr_state_t              state_reg, state_next;
    logic [LCW-1:0]         load_cnt_reg, load_cnt_next;
    logic [PCW-1:0]         prog_cnt_reg, prog_cnt_next;
    logic [ARRAY_AW-PAGE_LSB-1:0] page_reg, page_next;
    logic [PAGE_BYTES-1:0]  valid_reg, valid_next;
    logic [DATA_W-1:0]      buf_reg [PAGE_BYTES];
    logic [DATA_W-1:0]      buf_next [PAGE_BYTES];
    logic                   busy_plane_reg, busy_plane_next;
    logic                   busy_reg, busy_next;

    // array and section enables are nonvolatile: no reset
    logic [DATA_W-1:0]        mem_reg [2**ARRAY_AW];
    logic [SECTION_COUNT-1:0] sect_en_reg, sect_en_next;
    logic                     mem_we;
    logic [ARRAY_AW-1:0]      mem_waddr;
    logic [DATA_W-1:0]        mem_wdata;

    logic strobe_fall, phase_rise, phase_fall, wr_start, wr_data, busy_hit;

    always_comb begin
        strobe_fall = strobe_d_reg && !strobe_s;
        phase_rise  = !phase_d_reg && phase_s;
        phase_fall  = phase_d_reg && !phase_s;
        wr_start    = phase_rise && !rnw_s && sel_reg;
        wr_data     = phase_fall && !rnw_s && sel_reg;
        busy_hit    = busy_reg && (plane_of(addr_reg) == busy_plane_reg);
    end

    always_comb begin
        strobe_d_next = strobe_s;
        phase_d_next  = phase_s;
        addr_next     = addr_reg;
        sel_next      = sel_reg;
        toggle_next   = toggle_reg;
        // address only while the phase clock is low
        if (strobe_fall && !phase_s) begin
            addr_next = {upper_s, ad_s};
            sel_next  = sel_s;
        end
        // each read of the busy plane flips the status bit
        if (phase_fall && rnw_s && sel_reg && busy_hit)
            toggle_next = !toggle_reg;
        if (!busy_reg)
            toggle_next = toggle_reg;
        if (busy_hit) begin
            dout_next = STATUS_BASE;
            dout_next[TOGGLE_BIT] = toggle_reg;
        end else begin
            dout_next = mem_reg[addr_reg[ARRAY_AW-1:0]];
        end
        oe_n_next    = !(phase_s && rnw_s && sel_reg);
        standby_next = !sel_s && !strobe_s;
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            strobe_d_reg <= 1'b0;
            phase_d_reg  <= 1'b0;
            addr_reg     <= ADDR_RESET;
            sel_reg      <= 1'b0;
            toggle_reg   <= 1'b0;
            dout_reg     <= DATA_RESET;
            oe_n_reg     <= 1'b1;
            standby_reg  <= 1'b0;
        end else begin
            strobe_d_reg <= strobe_d_next;
            phase_d_reg  <= phase_d_next;
            addr_reg     <= addr_next;
            sel_reg      <= sel_next;
            toggle_reg   <= toggle_next;
            dout_reg     <= dout_next;
            oe_n_reg     <= oe_n_next;
            standby_reg  <= standby_next;
        end
    end

    logic [PIW-1:0] pidx;
    logic           page_ok;

    always_comb begin
        state_next      = state_reg;
        load_cnt_next   = load_cnt_reg;
        prog_cnt_next   = prog_cnt_reg;
        page_next       = page_reg;
        valid_next      = valid_reg;
        buf_next        = buf_reg;
        busy_plane_next = busy_plane_reg;
        busy_next       = busy_reg;
        mem_we          = 1'b0;
        mem_waddr       = '0;
        mem_wdata       = DATA_RESET;
        pidx            = addr_reg[PIW-1:0];
        page_ok         = sect_en_reg[addr_reg[ARRAY_AW-1:SECTION_LSB]]
                          && !busy_reg;
        case (state_reg)
            ST_IDLE: begin
                if (wr_start && page_ok) begin
                    state_next    = ST_LOAD;
                    load_cnt_next = LCW'(LOAD_CYCLES);
                    page_next     = addr_reg[ARRAY_AW-1:PAGE_LSB];
                    valid_next    = '0;
                end
            end
            ST_LOAD: begin
                if (load_cnt_reg != '0)
                    load_cnt_next = load_cnt_reg - LCW'(1);
                // every write phase restarts the timer, even one that is dropped
                if (wr_start)
                    load_cnt_next = LCW'(LOAD_CYCLES);
                // bytes of another page are dropped
                if (wr_data && page_ok && addr_reg[ARRAY_AW-1:PAGE_LSB] == page_reg) begin
                    buf_next[pidx]   = ad_s;
                    valid_next[pidx] = 1'b1;
                end
                if (gate_s) begin
                    state_next = ST_IDLE;
                end else if (load_cnt_reg == LCW'(1) && valid_reg != '0) begin
                    state_next      = ST_PROG;
                    prog_cnt_next   = '0;
                    busy_next       = 1'b1;
                    busy_plane_next = page_reg[PLANE_BIT-PAGE_LSB];
                end else if (load_cnt_reg == LCW'(1)) begin
                    state_next = ST_IDLE;
                end
            end
            ST_PROG: begin
                prog_cnt_next = prog_cnt_reg + PCW'(1);
                if (prog_cnt_reg < PCW'(PAGE_BYTES)) begin
                    mem_we    = valid_reg[prog_cnt_reg[PIW-1:0]];
                    mem_waddr = {page_reg, prog_cnt_reg[PIW-1:0]};
                    mem_wdata = buf_reg[prog_cnt_reg[PIW-1:0]];
                end
                if (prog_cnt_reg == PCW'(PROG_CYCLES - 1)) begin
                    state_next = ST_IDLE;
                    busy_next  = 1'b0;
                end
            end
            default: begin
                state_next = ST_IDLE;
                busy_next  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= ST_IDLE;
            load_cnt_reg   <= '0;
            prog_cnt_reg   <= '0;
            page_reg       <= '0;
            valid_reg      <= '0;
            busy_plane_reg <= 1'b0;
            busy_reg       <= 1'b0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                buf_reg[i] <= DATA_RESET;
            end
        end else begin
            state_reg      <= state_next;
            load_cnt_reg   <= load_cnt_next;
            prog_cnt_reg   <= prog_cnt_next;
            page_reg       <= page_next;
            valid_reg      <= valid_next;
            busy_plane_reg <= busy_plane_next;
            busy_reg       <= busy_next;
            buf_reg        <= buf_next;
        end
    end

    always_comb sect_en_next = SECTION_ENABLE_LOAD ? SECTION_ENABLE_DATA : sect_en_reg;

    always_ff @(posedge CLK) begin
        sect_en_reg <= sect_en_next;
        if (mem_we)
            mem_reg[mem_waddr] <= mem_wdata;
    end

    assign MUXED_ADDR_DATA_OUT  = dout_reg;
    assign MUXED_ADDR_DATA_OE_N = oe_n_reg;
    assign STANDBY              = standby_reg;
    assign PROG_BUSY            = busy_reg;
endmodule

// ---- eeprom_port_checker_assertions.sv ----
`timescale 1ns/10ps
module eeprom_port_checker #(
    parameter int LOAD_CYCLES = 50,
    parameter int PROG_CYCLES = 100
) (
    input wire logic       CLK,
    input wire logic       RSTN,
    input wire logic [7:0] UPPER_ADDR_INPUTS,
    input wire logic [7:0] MUXED_ADDR_DATA_IN,
    input wire logic [7:0] MUXED_ADDR_DATA_OUT,
    input wire logic       MUXED_ADDR_DATA_OE_N,
    input wire logic       ADDR_LATCH_STROBE,
    input wire logic       BUS_PHASE_CLOCK,
    input wire logic       READ_NOT_WRITE,
    input wire logic       CHIP_SELECT,
    input wire logic       WRITE_GATE_INPUT,
    input wire logic       SECTION_ENABLE_LOAD,
    input wire logic [7:0] SECTION_ENABLE_DATA,
    input wire logic       STANDBY,
    input wire logic       PROG_BUSY
);
    logic [19:0] busy_cnt_reg;
    logic [19:0] busy_cnt_next;
    logic [19:0] quiet_cnt_reg;
    logic [19:0] quiet_cnt_next;
    logic        phase_reg;

    // quiet counter restarts on each write-phase rising edge, saturates
    always_comb begin
        busy_cnt_next  = PROG_BUSY ? busy_cnt_reg + 20'h1 : 20'h0;
        quiet_cnt_next = quiet_cnt_reg + {19'h0, ~&quiet_cnt_reg};
        if (BUS_PHASE_CLOCK && !phase_reg && !READ_NOT_WRITE) begin
            quiet_cnt_next = 20'h0;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            busy_cnt_reg  <= 20'h0;
            quiet_cnt_reg <= 20'h0;
            phase_reg     <= 1'b0;
        end else begin
            busy_cnt_reg  <= busy_cnt_next;
            quiet_cnt_reg <= quiet_cnt_next;
            phase_reg     <= BUS_PHASE_CLOCK;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    a_standby_on: assert property ((!CHIP_SELECT && !ADDR_LATCH_STROBE)[*8] |-> STANDBY)
        else $error("standby not entered");
    a_standby_off: assert property (CHIP_SELECT[*8] |-> !STANDBY)
        else $error("standby while selected");
    a_gate_blocks: assert property (WRITE_GATE_INPUT[*8] |-> !$rose(PROG_BUSY))
        else $error("programming began with gate high");
    a_prog_quiet: assert property ($rose(PROG_BUSY) |-> quiet_cnt_reg >= LOAD_CYCLES)
        else $error("programming began before load timeout");
    a_prog_length: assert property ($fell(PROG_BUSY) |->
        busy_cnt_reg >= PROG_CYCLES - 1 && busy_cnt_reg <= PROG_CYCLES + 1)
        else $error("programming time wrong");
    a_oe_release: assert property ($fell(BUS_PHASE_CLOCK) |-> ##[1:4] MUXED_ADDR_DATA_OE_N)
        else $error("lines still driven after phase fall");
    a_oe_read_dir: assert property (!MUXED_ADDR_DATA_OE_N |->
        $past(READ_NOT_WRITE, 2) && $past(READ_NOT_WRITE, 4))
        else $error("lines driven outside a read");
    a_write_no_drive: assert property ((!READ_NOT_WRITE)[*6] |-> MUXED_ADDR_DATA_OE_N)
        else $error("lines driven during write");

    cover property ($rose(PROG_BUSY));
    cover property ($fell(MUXED_ADDR_DATA_OE_N));
    cover property ($rose(STANDBY));
endmodule

bind muxed_bus_eeprom_write_port eeprom_port_checker #(
    .LOAD_CYCLES(LOAD_CYCLES),
    .PROG_CYCLES(PROG_CYCLES)
) eeprom_port_checker_i (
    .CLK                  (CLK),
    .RSTN                 (RSTN),
    .UPPER_ADDR_INPUTS    (UPPER_ADDR_INPUTS),
    .MUXED_ADDR_DATA_IN   (MUXED_ADDR_DATA_IN),
    .MUXED_ADDR_DATA_OUT  (MUXED_ADDR_DATA_OUT),
    .MUXED_ADDR_DATA_OE_N (MUXED_ADDR_DATA_OE_N),
    .ADDR_LATCH_STROBE    (ADDR_LATCH_STROBE),
    .BUS_PHASE_CLOCK      (BUS_PHASE_CLOCK),
    .READ_NOT_WRITE       (READ_NOT_WRITE),
    .CHIP_SELECT          (CHIP_SELECT),
    .WRITE_GATE_INPUT     (WRITE_GATE_INPUT),
    .SECTION_ENABLE_LOAD  (SECTION_ENABLE_LOAD),
    .SECTION_ENABLE_DATA  (SECTION_ENABLE_DATA),
    .STANDBY              (STANDBY),
    .PROG_BUSY            (PROG_BUSY)
);

// ---- eeprom_host_model.sv ----
`timescale 1ns/10ps
module eeprom_host_model (
    input  wire logic       CLK,
    input  wire logic [7:0] MUXED_ADDR_DATA_OUT,
    input  wire logic       MUXED_ADDR_DATA_OE_N,
    output logic      [7:0] UPPER_ADDR_INPUTS,
    output logic      [7:0] MUXED_ADDR_DATA_IN,
    output logic            ADDR_LATCH_STROBE,
    output logic            BUS_PHASE_CLOCK,
    output logic            READ_NOT_WRITE,
    output logic            CHIP_SELECT
);
    logic [7:0] host_val = 8'h00;
    logic       host_en  = 1'b0;

    // undriven lines show the inverse of the last value
    assign MUXED_ADDR_DATA_IN = !MUXED_ADDR_DATA_OE_N ? MUXED_ADDR_DATA_OUT :
                                host_en ? host_val : ~host_val;

    initial begin
        UPPER_ADDR_INPUTS = 8'h00;
        ADDR_LATCH_STROBE = 1'b0;
        BUS_PHASE_CLOCK   = 1'b0;
        READ_NOT_WRITE    = 1'b1;
        CHIP_SELECT       = 1'b0;
    end

    task automatic access(input logic [15:0] a, input logic rnw, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge CLK);
        CHIP_SELECT       <= 1'b1;
        UPPER_ADDR_INPUTS <= a[15:8];
        host_val          <= a[7:0];
        host_en           <= 1'b1;
        ADDR_LATCH_STROBE <= 1'b1;
        repeat (4) @(posedge CLK);
        ADDR_LATCH_STROBE <= 1'b0;
        repeat (4) @(posedge CLK);
        READ_NOT_WRITE    <= rnw;
        host_val          <= d;
        host_en           <= !rnw;
        repeat (4) @(posedge CLK);
        BUS_PHASE_CLOCK   <= 1'b1;
        repeat (6) @(posedge CLK);
        q = MUXED_ADDR_DATA_IN;
        BUS_PHASE_CLOCK   <= 1'b0;
        repeat (4) @(posedge CLK);
        host_en           <= 1'b0;
        CHIP_SELECT       <= 1'b0;
        READ_NOT_WRITE    <= 1'b1;
    endtask
endmodule

// ---- tb_muxed_bus_eeprom_write_port.sv ----
`timescale 1ns/10ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module tb_muxed_bus_eeprom_write_port;
    localparam int LOAD_N = 50;
    localparam int PROG_N = 100;
    logic       CLK = 1'b0, RSTN = 1'b0, WRITE_GATE_INPUT = 1'b0, SECTION_ENABLE_LOAD = 1'b0;
    logic [7:0] SECTION_ENABLE_DATA = 8'hff, UPPER_ADDR_INPUTS, MUXED_ADDR_DATA_IN;
    logic [7:0] MUXED_ADDR_DATA_OUT, v1, v2;
    logic       MUXED_ADDR_DATA_OE_N, ADDR_LATCH_STROBE, BUS_PHASE_CLOCK, READ_NOT_WRITE;
    logic       CHIP_SELECT, STANDBY, PROG_BUSY;
    int         n_fail = 0, num_checks = 0;

    muxed_bus_eeprom_write_port #(
        .LOAD_CYCLES(LOAD_N),
        .PROG_CYCLES(PROG_N)
    ) muxed_bus_eeprom_write_port_i (
        .CLK                  (CLK),
        .RSTN                 (RSTN),
        .UPPER_ADDR_INPUTS    (UPPER_ADDR_INPUTS),
        .MUXED_ADDR_DATA_IN   (MUXED_ADDR_DATA_IN),
        .MUXED_ADDR_DATA_OUT  (MUXED_ADDR_DATA_OUT),
        .MUXED_ADDR_DATA_OE_N (MUXED_ADDR_DATA_OE_N),
        .ADDR_LATCH_STROBE    (ADDR_LATCH_STROBE),
        .BUS_PHASE_CLOCK      (BUS_PHASE_CLOCK),
        .READ_NOT_WRITE       (READ_NOT_WRITE),
        .CHIP_SELECT          (CHIP_SELECT),
        .WRITE_GATE_INPUT     (WRITE_GATE_INPUT),
        .SECTION_ENABLE_LOAD  (SECTION_ENABLE_LOAD),
        .SECTION_ENABLE_DATA  (SECTION_ENABLE_DATA),
        .STANDBY              (STANDBY),
        .PROG_BUSY            (PROG_BUSY)
    );
    eeprom_host_model eeprom_host_model_i (
        .CLK                  (CLK),
        .MUXED_ADDR_DATA_OUT  (MUXED_ADDR_DATA_OUT),
        .MUXED_ADDR_DATA_OE_N (MUXED_ADDR_DATA_OE_N),
        .UPPER_ADDR_INPUTS    (UPPER_ADDR_INPUTS),
        .MUXED_ADDR_DATA_IN   (MUXED_ADDR_DATA_IN),
        .ADDR_LATCH_STROBE    (ADDR_LATCH_STROBE),
        .BUS_PHASE_CLOCK      (BUS_PHASE_CLOCK),
        .READ_NOT_WRITE       (READ_NOT_WRITE),
        .CHIP_SELECT          (CHIP_SELECT)
    );

    always #5 CLK = ~CLK;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        eeprom_host_model_i.access(a, 1'b0, d, q);
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] q);
        eeprom_host_model_i.access(a, 1'b1, 8'h00, q);
    endtask

    task automatic wait_busy(input logic lvl, input int bound);
        int n;
        n = 0;
        while (PROG_BUSY !== lvl && n < bound) begin
            @(posedge CLK);
            n++;
        end
        if (PROG_BUSY !== lvl) begin
            n_fail++;
            $display("unexpected at %0t: busy wait ran out", $time);
            give_verdict();
        end
    endtask

    task automatic set_enables(input logic [7:0] en);
        SECTION_ENABLE_DATA <= en;
        SECTION_ENABLE_LOAD <= 1'b1;
        @(posedge CLK);
        SECTION_ENABLE_LOAD <= 1'b0;
        @(posedge CLK);
    endtask

    task automatic test_plane_byte();
        wr(16'h1000, 8'ha5);
        wait_busy(1'b1, LOAD_N + 40);
        wait_busy(1'b0, PROG_N + 10);
        rd(16'h1000, v1);
        `CHK(v1, 8'ha5)
        $display("plane byte test done");
    endtask

    task automatic test_page_poll();
        wr(16'h0040, 8'h11);
        wr(16'h0041, 8'h22);
        wr(16'h005f, 8'h33);
        wait_busy(1'b1, LOAD_N + 40);
        rd(16'h0040, v1);
        rd(16'h0040, v2);
        `CHK(v1 ^ v2, 8'h40)
        `CHK(v1 & 8'hbf, 8'h00)
        rd(16'h1000, v1);
        `CHK(v1, 8'ha5)
        `CHK(PROG_BUSY, 1'b1)
        wait_busy(1'b0, PROG_N + 10);
        rd(16'h0040, v1);
        `CHK(v1, 8'h11)
        rd(16'h0041, v1);
        `CHK(v1, 8'h22)
        rd(16'h005f, v1);
        `CHK(v1, 8'h33)
        $display("page poll test done");
    endtask

    task automatic test_locked();
        set_enables(8'hfe);
        // enables and array must survive a reset
        RSTN <= 1'b0;
        repeat (4) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (4) @(posedge CLK);
        `CHK(STANDBY, 1'b1)
        wr(16'h0040, 8'h99);
        repeat (LOAD_N + 20) @(posedge CLK);
        `CHK(PROG_BUSY, 1'b0)
        rd(16'h0040, v1);
        `CHK(v1, 8'h11)
        set_enables(8'hff);
        $display("locked section test done");
    endtask

    task automatic test_gate();
        wr(16'h0041, 8'h77);
        WRITE_GATE_INPUT <= 1'b1;
        repeat (LOAD_N + 20) @(posedge CLK);
        `CHK(PROG_BUSY, 1'b0)
        WRITE_GATE_INPUT <= 1'b0;
        rd(16'h0041, v1);
        `CHK(v1, 8'h22)
        $display("write gate test done");
    endtask

    initial begin
        repeat (8) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (4) @(posedge CLK);
        set_enables(8'hff);
        repeat (8) @(posedge CLK);
        `CHK(STANDBY, 1'b1)
        test_plane_byte();
        test_page_poll();
        test_locked();
        test_gate();
        give_verdict();
    end
endmodule
